/* hw/mtc_pad.sv */
// Short-frame padding stage between the FIFO drain and the MII transmitter
`timescale 1ns/10ps
module mtc_pad
	import mtc_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic pad_enable,
	input wire mtc_byte_t in_byte,
	output logic in_ready,
	output mtc_byte_t out_byte
);

	logic [7:0] count_q;
	logic padding_q;
	logic gap_q;
	logic short_frame;

	// Frame would end before the minimum length
	assign short_frame = (count_q < MTC_MIN_FRAME_BYTES - 8'h01);
	assign in_ready = !padding_q;

	// ---------------------------------------------------------------
	// Byte counter and pad insertion
	// ---------------------------------------------------------------
	// Padding replaces the supplied last flag; the FIFO is held while zeros go out.
	// Zeros leave every second cycle, since the serialiser needs two cycles a byte
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			count_q <= 8'h00;
			padding_q <= 1'b0;
			gap_q <= 1'b0;
			out_byte <= '0;
		end
		else if (padding_q)
		begin
			gap_q <= !gap_q;
			if (gap_q)
			begin
				out_byte.valid <= 1'b0;
				out_byte.last <= 1'b0;
			end
			else
			begin
				out_byte.valid <= 1'b1;
				out_byte.data <= 8'h00;
				out_byte.last <= !short_frame;
				count_q <= short_frame ? count_q + 8'h01 : 8'h00;
				padding_q <= short_frame;
			end
		end
		else if (in_byte.valid)
		begin
			out_byte.valid <= 1'b1;
			out_byte.data <= in_byte.data;
			if (in_byte.last && pad_enable && short_frame)
			begin
				out_byte.last <= 1'b0;
				padding_q <= 1'b1;
				gap_q <= 1'b1;
				count_q <= count_q + 8'h01;
			end
			else
			begin
				// Without padding a short frame leaves as supplied
				out_byte.last <= in_byte.last;
				if (in_byte.last)
					count_q <= 8'h00;
				else if (count_q != 8'hFF)
					count_q <= count_q + 8'h01;
			end
		end
		else
		begin
			out_byte.valid <= 1'b0;
			out_byte.last <= 1'b0;
		end
	end

endmodule

/* hw/mtc_top.sv */
// Transmit configuration register and the transmit controls it governs
`timescale 1ns/10ps
//
// Summary of operation
// - Register is 32 bits; hard and soft reset both load 00800102h.
// - Bit 31 set ignores carrier sense; clear monitors and reports it.
// - Bit 30 set ignores the post-packet heartbeat; clear monitors it.
// - Bit 29 loops transmit to receive and disables both MII sides.
// - Packets received in loopback carry the looped packet flag.
// - Bit 28 set pads short transmit frames up to 64 bytes.
// - Bit 28 clear sends short frames exactly as supplied.
// - Bits 24..23 ignore writes and always read 01.
// - Bits 22..20 set burst: 000 is 128 words, else 1 to 64.
// - Fill level, 32-byte units, gates host-bus fetch on FIFO free space.
// - Drain level, 32-byte units, or one whole packet, starts transmission.
module mtc_top
	import mtc_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	// Soft reset command from the MAC command register
	input wire logic soft_reset,
	// Transmit and receive enables from the MAC command register
	input wire logic tx_enable,
	input wire logic rx_enable,
	// Transmit FIFO state and DMA side
	input wire logic [11:0] fifo_free_bytes,
	input wire logic [11:0] fifo_used_bytes,
	input wire logic fifo_has_packet,
	input wire logic dma_want_fetch,
	output logic dma_fetch_allow,
	output logic [7:0] dma_burst_words,
	output logic tx_start,
	// Bytes drained from the transmit FIFO
	input wire logic [7:0] tx_byte_data,
	input wire logic tx_byte_valid,
	input wire logic tx_byte_last,
	output logic tx_byte_ready,
	// MII transmit and receive pins
	output logic [3:0] mii_txd,
	output logic mii_tx_en,
	input wire logic mii_crs,
	input wire logic mii_col,
	input wire logic [3:0] mii_rxd,
	input wire logic mii_rx_dv,
	// Receive side of the MAC
	output logic [3:0] rx_nibble,
	output logic rx_nibble_valid,
	output logic looped_packet_flag
);

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	logic [31:0] transmit_config_q;
	logic [31:0] transmit_config_d;
	logic [1:0] tx_status_q;
	logic [31:0] rdata_d;
	mtc_cfg_t cfg;
	mtc_byte_t pad_in;
	mtc_byte_t pad_out;
	logic pad_ready;
	logic crs_s1_q;
	logic crs_s2_q;
	logic col_s1_q;
	logic col_s2_q;
	logic [3:0] rxd_s1_q;
	logic [3:0] rxd_s2_q;
	logic dv_s1_q;
	logic dv_s2_q;
	logic [7:0] tx_hold_q;
	logic hold_valid_q;
	logic hold_last_q;
	logic hi_nibble_q;
	logic frame_end;
	logic [2:0] hb_wait_q;
	logic crs_seen_q;

	typedef enum logic [1:0] {MTC_TX_IDLE, MTC_TX_SEND, MTC_TX_HEARTBEAT} mtc_tx_state_t;
	mtc_tx_state_t tx_state_q;

	// Burst code to word count; code zero is the largest burst
	function automatic logic [7:0] mtc_burst_words(input logic [2:0] code);
		logic [7:0] words;
		words = 8'h00;
		if (code == 3'h0)
			words = 8'h80;
		else
			words = 8'(8'h01 << (code - 3'h1));
		return words;
	endfunction

	// Level field in 32-byte units to bytes
	function automatic logic [11:0] mtc_level_bytes(input logic [5:0] level);
		return {1'b0, level, 5'h00};
	endfunction

	// ---------------------------------------------------------------
	// Register write
	// ---------------------------------------------------------------
	// Only writable fields follow the write data; fixed bits come from the constant
	always_comb
	begin
		transmit_config_d = (reg_wdata & MTC_WRITE_MASK)
			| (MTC_TRANSMIT_CONFIG_RESET & ~MTC_WRITE_MASK);
	end

	// Hard and soft reset load the same value
	always_ff @(posedge mclk)
	begin
		if (!resetn || soft_reset)
			transmit_config_q <= MTC_TRANSMIT_CONFIG_RESET;
		else if (reg_write && reg_addr == MTC_ADDR_TRANSMIT_CONFIG)
			transmit_config_q <= transmit_config_d;
	end

	// ---------------------------------------------------------------
	// Register read
	// ---------------------------------------------------------------
	always_comb
	begin
		case (reg_addr)
			MTC_ADDR_TRANSMIT_CONFIG: rdata_d = transmit_config_q;
			MTC_ADDR_TX_STATUS: rdata_d = {30'h0000_0000, tx_status_q};
			default: rdata_d = MTC_UNMAPPED_READ;
		endcase
	end

	// Data stand only in the cycle after the strobe
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			reg_rdata <= 32'h0000_0000;
		else if (reg_read)
			reg_rdata <= rdata_d;
		else
			reg_rdata <= 32'h0000_0000;
	end

	// ---------------------------------------------------------------
	// Decoded configuration
	// ---------------------------------------------------------------
	always_comb
	begin
		cfg.cs_ignore = transmit_config_q[MTC_BIT_CS_IGNORE];
		cfg.heartbeat_ignore = transmit_config_q[MTC_BIT_HEARTBEAT_IGNORE];
		cfg.internal_loopback = transmit_config_q[MTC_BIT_INTERNAL_LOOPBACK];
		cfg.auto_pad_enable = transmit_config_q[MTC_BIT_AUTO_PAD_ENABLE];
		cfg.max_burst_words = mtc_burst_words(transmit_config_q[MTC_BURST_HI:MTC_BURST_LO]);
		cfg.fill_bytes = mtc_level_bytes(transmit_config_q[MTC_FILL_HI:MTC_FILL_LO]);
		cfg.drain_bytes = mtc_level_bytes(transmit_config_q[MTC_DRAIN_HI:MTC_DRAIN_LO]);
	end

	// ---------------------------------------------------------------
	// FIFO thresholds and burst limit
	// ---------------------------------------------------------------
	// Zero levels are left to software to avoid; hardware does not guard them
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			dma_fetch_allow <= 1'b0;
			dma_burst_words <= 8'h00;
			tx_start <= 1'b0;
		end
		else
		begin
			dma_fetch_allow <= dma_want_fetch && tx_enable
				&& (fifo_free_bytes >= cfg.fill_bytes);
			dma_burst_words <= cfg.max_burst_words;
			tx_start <= tx_enable && (tx_state_q == MTC_TX_IDLE)
				&& ((fifo_used_bytes >= cfg.drain_bytes) || fifo_has_packet);
		end
	end

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	// Two stages before any logic looks at a pin
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			crs_s1_q <= 1'b0;
			crs_s2_q <= 1'b0;
			col_s1_q <= 1'b0;
			col_s2_q <= 1'b0;
			rxd_s1_q <= 4'h0;
			rxd_s2_q <= 4'h0;
			dv_s1_q <= 1'b0;
			dv_s2_q <= 1'b0;
		end
		else
		begin
			crs_s1_q <= mii_crs;
			crs_s2_q <= crs_s1_q;
			col_s1_q <= mii_col;
			col_s2_q <= col_s1_q;
			rxd_s1_q <= mii_rxd;
			rxd_s2_q <= rxd_s1_q;
			dv_s1_q <= mii_rx_dv;
			dv_s2_q <= dv_s1_q;
		end
	end

	// ---------------------------------------------------------------
	// Padding stage
	// ---------------------------------------------------------------
	assign pad_in = {tx_byte_valid && tx_enable, tx_byte_last, tx_byte_data};

	mtc_pad u_pad (
		.mclk(mclk),
		.resetn(resetn),
		.pad_enable(cfg.auto_pad_enable),
		.in_byte(pad_in),
		.in_ready(pad_ready),
		.out_byte(pad_out)
	);

	// Upstream stalls while padding or while a byte waits for its second nibble
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			tx_byte_ready <= 1'b0;
		else
			tx_byte_ready <= pad_ready && !hold_valid_q;
	end

	// ---------------------------------------------------------------
	// Nibble serialiser toward MII or the loopback path
	// ---------------------------------------------------------------
	assign frame_end = hold_valid_q && hi_nibble_q && hold_last_q;

	// A new byte is taken only when the hold is empty or its high nibble goes out;
	// the padding stage spaces its zeros to match, the FIFO must honour ready
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			tx_hold_q <= 8'h00;
			hold_valid_q <= 1'b0;
			hold_last_q <= 1'b0;
			hi_nibble_q <= 1'b0;
		end
		else if (hold_valid_q)
		begin
			hi_nibble_q <= !hi_nibble_q;
			if (hi_nibble_q)
				hold_valid_q <= pad_out.valid;
			if (hi_nibble_q)
			begin
				tx_hold_q <= pad_out.data;
				hold_last_q <= pad_out.last;
			end
		end
		else if (pad_out.valid)
		begin
			tx_hold_q <= pad_out.data;
			hold_last_q <= pad_out.last;
			hold_valid_q <= 1'b1;
			hi_nibble_q <= 1'b0;
		end
	end

	// Loopback keeps mii_tx_en low; mii_txd still follows the held nibbles
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			mii_txd <= 4'h0;
			mii_tx_en <= 1'b0;
		end
		else
		begin
			mii_tx_en <= hold_valid_q && !cfg.internal_loopback;
			mii_txd <= hi_nibble_q ? tx_hold_q[7:4] : tx_hold_q[3:0];
		end
	end

	// Receive path takes transmit nibbles in loopback and ignores the MII pins
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			rx_nibble <= 4'h0;
			rx_nibble_valid <= 1'b0;
			looped_packet_flag <= 1'b0;
		end
		else if (cfg.internal_loopback)
		begin
			rx_nibble <= hi_nibble_q ? tx_hold_q[7:4] : tx_hold_q[3:0];
			rx_nibble_valid <= hold_valid_q;
			looped_packet_flag <= 1'b1;
		end
		else
		begin
			rx_nibble <= rxd_s2_q;
			rx_nibble_valid <= dv_s2_q && rx_enable;
			looped_packet_flag <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Carrier and heartbeat monitor
	// ---------------------------------------------------------------
	// Heartbeat is sought for a few cycles after each frame
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			tx_state_q <= MTC_TX_IDLE;
			crs_seen_q <= 1'b0;
			hb_wait_q <= 3'h0;
		end
		else
		begin
			case (tx_state_q)
				MTC_TX_IDLE:
					if (hold_valid_q)
						tx_state_q <= MTC_TX_SEND;
				MTC_TX_SEND:
					if (frame_end)
					begin
						tx_state_q <= MTC_TX_HEARTBEAT;
						hb_wait_q <= 3'h7;
					end
				MTC_TX_HEARTBEAT:
					if (col_s2_q || hb_wait_q == 3'h0)
						tx_state_q <= MTC_TX_IDLE;
					else
						hb_wait_q <= hb_wait_q - 3'h1;
				default:
					tx_state_q <= MTC_TX_IDLE;
			endcase
			if (tx_state_q == MTC_TX_IDLE)
				crs_seen_q <= 1'b0;
			else if (crs_s2_q)
				crs_seen_q <= 1'b1; // Carrier lags tx_en, so any sight of it in the frame counts
		end
	end

	// Status bits are sticky until the next hard or soft reset
	always_ff @(posedge mclk)
	begin
		if (!resetn || soft_reset)
			tx_status_q <= 2'b00;
		else if (!cfg.internal_loopback)
		begin
			if (tx_state_q == MTC_TX_HEARTBEAT && (col_s2_q || hb_wait_q == 3'h0)
				&& !crs_seen_q && !cfg.cs_ignore)
				tx_status_q[MTC_STS_CARRIER_LOST] <= 1'b1;
			if (tx_state_q == MTC_TX_HEARTBEAT && hb_wait_q == 3'h0 && !col_s2_q
				&& !cfg.heartbeat_ignore)
				tx_status_q[MTC_STS_HEARTBEAT_MISS] <= 1'b1;
		end
	end

endmodule

/* inc/mtc_pkg.sv */
// Package for the transmit configuration block: offsets, fields, reset values, carriers
package mtc_pkg;

	// Register map
	localparam logic [7:0] MTC_ADDR_TRANSMIT_CONFIG = 8'h24;
	localparam logic [7:0] MTC_ADDR_TX_STATUS = 8'h28;
	localparam logic [31:0] MTC_TRANSMIT_CONFIG_RESET = 32'h0080_0102;
	localparam logic [31:0] MTC_UNMAPPED_READ = 32'h0000_0000;

	// Field positions of transmit_config
	localparam int MTC_BIT_CS_IGNORE = 31;
	localparam int MTC_BIT_HEARTBEAT_IGNORE = 30;
	localparam int MTC_BIT_INTERNAL_LOOPBACK = 29;
	localparam int MTC_BIT_AUTO_PAD_ENABLE = 28;
	localparam int MTC_FIXED_HI = 24;
	localparam int MTC_FIXED_LO = 23;
	localparam logic [1:0] MTC_FIXED_VALUE = 2'h1;
	localparam int MTC_BURST_HI = 22;
	localparam int MTC_BURST_LO = 20;
	localparam int MTC_FILL_HI = 13;
	localparam int MTC_FILL_LO = 8;
	localparam int MTC_DRAIN_HI = 5;
	localparam int MTC_DRAIN_LO = 0;
	// Writable bits: 31..28, 22..20, 13..8, 5..0
	localparam logic [31:0] MTC_WRITE_MASK = 32'hF070_3F3F;

	// Sizes
	localparam int MTC_LEVEL_UNIT_BYTES = 32;
	localparam logic [7:0] MTC_MIN_FRAME_BYTES = 8'h40;
	localparam int MTC_FIFO_BYTES = 2048;
	localparam int MTC_FIFO_LEVEL_W = 12;

	// Transmit status bits
	localparam int MTC_STS_CARRIER_LOST = 0;
	localparam int MTC_STS_HEARTBEAT_MISS = 1;

	// Values decoded from transmit_config for the datapath
	typedef struct packed {
		logic cs_ignore;
		logic heartbeat_ignore;
		logic internal_loopback;
		logic auto_pad_enable;
		logic [7:0] max_burst_words;
		logic [MTC_FIFO_LEVEL_W-1:0] fill_bytes;
		logic [MTC_FIFO_LEVEL_W-1:0] drain_bytes;
	} mtc_cfg_t;

	// One transmit byte heading for the MII or the loopback path
	typedef struct packed {
		logic valid;
		logic last;
		logic [7:0] data;
	} mtc_byte_t;

endpackage

/* sim/mtc_monitor.sv */
// Checker for the ports of the transmit configuration block
`timescale 1ns/10ps
module mtc_monitor
	import mtc_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [31:0] reg_rdata,
	input wire logic soft_reset,
	input wire logic tx_enable,
	input wire logic [11:0] fifo_free_bytes,
	input wire logic [11:0] fifo_used_bytes,
	input wire logic fifo_has_packet,
	input wire logic dma_want_fetch,
	input wire logic dma_fetch_allow,
	input wire logic [7:0] dma_burst_words,
	input wire logic tx_start,
	input wire logic mii_tx_en,
	input wire logic looped_packet_flag
);
	logic [31:0] cfg_q;
	logic [7:0] burst_exp;
	logic fetch_ok;
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	// ---
	// Shadow of the configuration word
	// ---
	// Both resets reload it, so no reset path can leave the shadow stale
	always_ff @(posedge mclk)
	begin
		if (!resetn || soft_reset)
			cfg_q <= MTC_TRANSMIT_CONFIG_RESET;
		else if (reg_write && reg_addr == MTC_ADDR_TRANSMIT_CONFIG)
			cfg_q <= (reg_wdata & MTC_WRITE_MASK) | 32'h0080_0000;
	end
	// Expected burst length and fetch permission
	always_comb
	begin
		burst_exp = (cfg_q[22:20] == 3'h0) ? 8'h80 : 8'h01 << (cfg_q[22:20] - 3'h1);
		fetch_ok = dma_want_fetch && tx_enable && fifo_free_bytes >= {1'b0, cfg_q[13:8], 5'h00};
	end
	// ---
	// Assertions
	// ---
	sequence s_cfg_rd;
		reg_read && reg_addr == MTC_ADDR_TRANSMIT_CONFIG ##1 1'b1;
	endsequence
	rd_config_a: assert property (s_cfg_rd |-> reg_rdata == $past(cfg_q))
		else $error("config read wrong");
	fixed_bits_a: assert property (s_cfg_rd |-> reg_rdata[24:23] == MTC_FIXED_VALUE)
		else $error("fixed field wrong");
	reserved_zero_a: assert property (s_cfg_rd |-> (reg_rdata & 32'h0E0F_C0C0) == 32'h0)
		else $error("reserved bits set");
	rd_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
		else $error("read data outside its cycle");
	burst_size_a: assert property ($past(resetn) && $stable(cfg_q) |-> dma_burst_words == burst_exp)
		else $error("burst length wrong");
	fetch_gate_a: assert property ($past(resetn) |-> dma_fetch_allow == $past(fetch_ok))
		else $error("fetch permission wrong");
	start_cause_a: assert property (tx_start |-> $past(tx_enable && (fifo_has_packet || fifo_used_bytes >= {1'b0, cfg_q[5:0], 5'h00})))
		else $error("start without cause");
	loop_quiet_a: assert property (cfg_q[29] && $past(cfg_q[29]) |-> !mii_tx_en)
		else $error("pins active in loopback");
	loop_flag_a: assert property ($past(resetn) |-> looped_packet_flag == $past(cfg_q[29]))
		else $error("loopback flag wrong");
endmodule

/* sim/mtc_phy.sv */
// Behavioural PHY on the MII side of the transmit block
`timescale 1ns/10ps
module mtc_phy
(
	input wire logic mclk,
	input wire logic mii_tx_en,
	input wire logic no_carrier,
	input wire logic no_heartbeat,
	output logic mii_crs,
	output logic mii_col,
	output logic [3:0] mii_rxd,
	output logic mii_rx_dv
);
	logic tx_d;
	logic [1:0] hb_q;
	initial
	begin
		tx_d = 1'b0;
		hb_q = 2'h0;
		mii_crs = 1'b0;
		mii_col = 1'b0;
		mii_rxd = 4'h5;
		mii_rx_dv = 1'b0;
	end
	// Carrier echoes our transmission; heartbeat comes a few cycles after it ends
	always @(posedge mclk)
	begin
		tx_d <= mii_tx_en;
		mii_crs <= mii_tx_en && !no_carrier;
		hb_q <= {hb_q[0], tx_d && !mii_tx_en && !no_heartbeat};
		mii_col <= hb_q[1];
		mii_rxd <= ~mii_rxd; // Idle lines toggle so stale data is never mistaken for real
		mii_rx_dv <= 1'b0;
	end
endmodule

/* sim/mtc_top_tb.sv */
// Testbench for the transmit configuration block
`timescale 1ns/10ps
module mtc_top_tb;
	import mtc_pkg::*;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic soft_reset = 1'b0;
	logic tx_enable = 1'b0;
	logic rx_enable = 1'b0;
	logic [11:0] fifo_free_bytes = 12'h000;
	logic [11:0] fifo_used_bytes = 12'h000;
	logic fifo_has_packet = 1'b0;
	logic dma_want_fetch = 1'b0;
	logic [7:0] tx_byte_data = 8'h00;
	logic tx_byte_valid = 1'b0;
	logic tx_byte_last = 1'b0;
	logic no_carrier = 1'b0;
	logic no_heartbeat = 1'b0;
	logic seen_start = 1'b0;
	logic [31:0] reg_rdata;
	logic [7:0] dma_burst_words;
	logic [3:0] mii_txd, mii_rxd, rx_nibble;
	logic dma_fetch_allow, tx_start, tx_byte_ready, mii_tx_en, mii_crs, mii_col;
	logic mii_rx_dv, rx_nibble_valid, looped_packet_flag;
	int n_fail = 0;
	int checks_done = 0;
	int n_nib = 0;
	int n_rx = 0;
	int n_sum = 0;
	int n_rsum = 0;
	mtc_top i_mtc_top (.mclk, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read,
		.reg_rdata, .soft_reset, .tx_enable, .rx_enable, .fifo_free_bytes,
		.fifo_used_bytes, .fifo_has_packet, .dma_want_fetch, .dma_fetch_allow,
		.dma_burst_words, .tx_start, .tx_byte_data, .tx_byte_valid, .tx_byte_last,
		.tx_byte_ready, .mii_txd, .mii_tx_en, .mii_crs, .mii_col, .mii_rxd, .mii_rx_dv,
		.rx_nibble, .rx_nibble_valid, .looped_packet_flag);
	mtc_phy i_mtc_phy (.mclk, .mii_tx_en, .no_carrier, .no_heartbeat, .mii_crs,
		.mii_col, .mii_rxd, .mii_rx_dv);
	// ---
	// Clock and observers
	// ---
	always #2 mclk = ~mclk;
	// Count nibbles on the pins and on the receive side
	always @(posedge mclk)
	begin
		if (mii_tx_en)
		begin
			n_nib <= n_nib + 1;
			n_sum <= n_sum + mii_txd;
		end
		if (rx_nibble_valid)
		begin
			n_rx <= n_rx + 1;
			n_rsum <= n_rsum + rx_nibble;
		end
		if (tx_start)
			seen_start <= 1'b1;
	end
	// ---
	// Tasks
	// ---
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge mclk);
		reg_write <= 1'b0;
	endtask
	task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] exp);
		@(posedge mclk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge mclk);
		reg_read <= 1'b0;
		#1;
		chk(what, reg_rdata & m, exp);
	endtask
	task automatic sr();
		@(posedge mclk);
		soft_reset <= 1'b1;
		@(posedge mclk);
		soft_reset <= 1'b0;
	endtask
	// Sends n bytes, then waits for the frame and the heartbeat window to pass
	task automatic frame(input int n);
		int t;
		n_nib = 0;
		n_rx = 0;
		n_sum = 0;
		n_rsum = 0;
		for (int i = 0; i < n; i++)
		begin
			t = 0;
			while (!tx_byte_ready && t < 40)
			begin
				cyc(1);
				t++;
			end
			chk("byte ready", 32'(t < 40), 32'h1);
			@(posedge mclk);
			tx_byte_data <= 8'(i + 1);
			tx_byte_valid <= 1'b1;
			tx_byte_last <= (i == n - 1);
			@(posedge mclk);
			tx_byte_valid <= 1'b0;
			cyc(2);
		end
		cyc(4);
		t = 0;
		while ((mii_tx_en || rx_nibble_valid) && t < 400)
		begin
			cyc(1);
			t++;
		end
		chk("frame drained", 32'(t < 400), 32'h1);
		cyc(16);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ---
	// Tests
	// ---
	// Loose bound: the frames dominate and take well under two thousand of the 15000 cycles
	initial
	begin
		#60000;
		n_fail++;
		summarize();
	end
	// Main sequence; transmitter is off for the register and burst tests and the level setup write, on for later config rewrites until loopback
	initial
	begin
		repeat (5) @(posedge mclk);
		resetn <= 1'b1;
		rdc("reset value", MTC_ADDR_TRANSMIT_CONFIG, 32'hFFFF_FFFF, 32'h0080_0102);
		wr(MTC_ADDR_TRANSMIT_CONFIG, 32'hFFFF_FFFF);
		rdc("all ones", MTC_ADDR_TRANSMIT_CONFIG, 32'hFFFF_FFFF, 32'hF0F0_3F3F);
		wr(MTC_ADDR_TRANSMIT_CONFIG, 32'h0F8F_C1C1);
		rdc("fixed field", MTC_ADDR_TRANSMIT_CONFIG, 32'hFFFF_FFFF, 32'h0080_0101);
		wr(8'h40, 32'hFFFF_FFFF);
		rdc("unmapped", 8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
		rdc("after unmapped", MTC_ADDR_TRANSMIT_CONFIG, 32'hFFFF_FFFF, 32'h0080_0101);
		sr();
		rdc("soft reset", MTC_ADDR_TRANSMIT_CONFIG, 32'hFFFF_FFFF, 32'h0080_0102);
		$display("register test done");
		for (int c = 0; c < 8; c++)
		begin
			wr(MTC_ADDR_TRANSMIT_CONFIG, 32'h0000_0101 | (32'(c) << 20));
			cyc(2);
			chk("burst", dma_burst_words, (c == 0) ? 32'h80 : 32'h1 << (c - 1));
		end
		$display("burst test done");
		wr(MTC_ADDR_TRANSMIT_CONFIG, 32'h0000_0202); // Levels kept legal
		@(posedge mclk);
		tx_enable <= 1'b1;
		dma_want_fetch <= 1'b1;
		fifo_free_bytes <= 12'h03F;
		fifo_used_bytes <= 12'h03F;
		cyc(4);
		chk("fetch below", dma_fetch_allow, 32'h0);
		chk("start below", seen_start, 32'h0);
		@(posedge mclk);
		fifo_free_bytes <= 12'h040;
		fifo_used_bytes <= 12'h040;
		cyc(4);
		chk("fetch at level", dma_fetch_allow, 32'h1);
		chk("start at level", seen_start, 32'h1);
		@(posedge mclk);
		fifo_used_bytes <= 12'h000;
		cyc(4);
		chk("start stops", tx_start, 32'h0);
		@(posedge mclk);
		fifo_has_packet <= 1'b1;
		cyc(4);
		chk("start on packet", tx_start, 32'h1);
		@(posedge mclk);
		fifo_has_packet <= 1'b0;
		dma_want_fetch <= 1'b0;
		$display("level test done");
		wr(MTC_ADDR_TRANSMIT_CONFIG, 32'h1000_0202);
		frame(10);
		chk("padded short", n_nib, 32'd128);
		chk("pad content", n_sum, 32'd55);
		frame(70);
		chk("padded long", n_nib, 32'd140);
		rdc("status clean", MTC_ADDR_TX_STATUS, 32'h3, 32'h0);
		wr(MTC_ADDR_TRANSMIT_CONFIG, 32'h0000_0202);
		frame(10);
		chk("unpadded", n_nib, 32'd20);
		chk("unpadded data", n_sum, 32'd55);
		$display("padding test done");
		no_heartbeat <= 1'b1;
		frame(10);
		rdc("heartbeat miss", MTC_ADDR_TX_STATUS, 32'h3, 32'h2);
		sr();
		wr(MTC_ADDR_TRANSMIT_CONFIG, 32'h4000_0202);
		frame(10);
		rdc("heartbeat ignored", MTC_ADDR_TX_STATUS, 32'h3, 32'h0);
		no_heartbeat <= 1'b0;
		no_carrier <= 1'b1;
		wr(MTC_ADDR_TRANSMIT_CONFIG, 32'h0000_0202);
		frame(10);
		rdc("carrier lost", MTC_ADDR_TX_STATUS, 32'h3, 32'h1);
		sr();
		no_heartbeat <= 1'b1;
		wr(MTC_ADDR_TRANSMIT_CONFIG, 32'hC000_0202); // Full duplex setup
		frame(10);
		rdc("both ignored", MTC_ADDR_TX_STATUS, 32'h3, 32'h0);
		no_carrier <= 1'b0;
		no_heartbeat <= 1'b0;
		$display("status test done");
		@(posedge mclk);
		tx_enable <= 1'b0; // Both sides off before looping
		wr(MTC_ADDR_TRANSMIT_CONFIG, 32'h2000_0202);
		cyc(2);
		chk("loop flag", looped_packet_flag, 32'h1);
		@(posedge mclk);
		tx_enable <= 1'b1;
		rx_enable <= 1'b1;
		frame(8);
		chk("pins in loopback", n_nib, 32'd0);
		chk("looped nibbles", n_rx, 32'd16);
		chk("looped data", n_rsum, 32'd36);
		$display("loopback test done");
		summarize();
	end
endmodule
bind mtc_top mtc_monitor i_mtc_monitor (.mclk, .resetn, .reg_addr, .reg_wdata, .reg_write,
	.reg_read, .reg_rdata, .soft_reset, .tx_enable, .fifo_free_bytes, .fifo_used_bytes,
	.fifo_has_packet, .dma_want_fetch, .dma_fetch_allow, .dma_burst_words, .tx_start,
	.mii_tx_en, .looped_packet_flag);
